// ---- hw/boot_command_interpreter.sv ----
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module boot_command_interpreter (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Serial character stream
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  output logic             o_rx_ready,
  output logic             o_tx_valid,
  output logic [7:0]       o_tx_data,
  input  wire logic        i_tx_ready,
  // Flash erase engine
  output logic             o_erase_req,
  output logic             o_erase_all,
  output logic [15:0]      o_erase_lo,
  output logic [15:0]      o_erase_hi,
  input  wire logic        i_erase_done,
  // Application start
  output logic             o_watchdog_enable,
  output logic             o_jump,
  output logic [15:0]      o_jump_addr
);
  import boot_cmd_pkg::*;

  typedef struct packed {
    state_t      st;
    logic        hi_nib;
    logic [3:0]  nib;
    logic [8:0]  idx;
    logic [7:0]  len;
    logic [7:0]  rtype;
    logic [7:0]  d0;
    logic [7:0]  d1;
    logic [7:0]  d2;
    logic [7:0]  d3;
    logic [7:0]  sum;
    logic        bad_hex;
    logic [7:0]  reply;
    logic [1:0]  rpos;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic        erase_req;
    logic        erase_all;
    logic [15:0] erase_lo;
    logic [15:0] erase_hi;
    logic        wdog;
    logic        jump;
    logic [15:0] jump_addr;
    logic        secure;
    logic [7:0]  last_reply;
    logic        wr_pend;
    logic        rd_pend;
    logic [7:0]  rd_addr;
    logic [31:0] hrdata;
  } core_t;

  core_t cur;
  core_t next_cur;

  // Hex digit to nibble; bit 4 flags a non-hex character
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) begin
      hex_val = {1'b0, 4'(c - 8'h30)};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      hex_val = {1'b0, 4'(c - 8'h37)};
    end else if (c >= 8'h61 && c <= 8'h66) begin
      hex_val = {1'b0, 4'(c - 8'h57)};
    end else begin
      hex_val = 5'h10;
    end
  endfunction

  // Reply character at position 0..2
  function automatic logic [7:0] reply_char(input logic [7:0] r, input logic [1:0] p);
    case (p)
      2'd0:    reply_char = r;
      2'd1:    reply_char = CH_CR;
      default: reply_char = CH_LF;
    endcase
  endfunction

  logic       rx_take;
  logic [4:0] hv;
  logic [7:0] byte_in;

  assign hv      = hex_val(i_rx_data);
  assign byte_in = {cur.nib, hv[3:0]};

  // Echo slot must be free before a character is taken
  assign o_rx_ready = !cur.tx_valid && (cur.st == ST_IDLE || cur.st == ST_FRAME);
  assign rx_take    = i_rx_valid && o_rx_ready;

  always_comb begin
    next_cur      = cur;
    next_cur.jump = 1'b0;

    // Transmit slot drains on acceptance
    if (cur.tx_valid && i_tx_ready) begin
      next_cur.tx_valid = 1'b0;
    end

    // Register bus: data phase of previous address phase
    if (cur.wr_pend && cur.rd_addr == REG_CTRL) begin
      next_cur.secure = i_hwdata[CTRL_SECURE_BIT];
    end
    next_cur.wr_pend = 1'b0;
    next_cur.rd_pend = 1'b0;
    if (i_hsel && i_hready && i_htrans[1]) begin
      next_cur.wr_pend = i_hwrite;
      next_cur.rd_pend = !i_hwrite;
      next_cur.rd_addr = i_haddr[7:0];
      case (i_haddr[7:0])
        REG_CTRL:  next_cur.hrdata = {31'h0, cur.secure};
        REG_STAT:  next_cur.hrdata = {13'h0, 3'(cur.st), cur.wdog, 7'h0, cur.last_reply};
        REG_ENTRY: next_cur.hrdata = {16'h0, API_ENTRY};
        REG_JUMP:  next_cur.hrdata = {16'h0, cur.jump_addr};
        default:   next_cur.hrdata = 32'h0000_0000;
      endcase
    end

    case (cur.st)
      ST_IDLE, ST_FRAME: begin
        if (rx_take) begin
          next_cur.tx_valid = 1'b1;
          next_cur.tx_data  = i_rx_data;
          if (i_rx_data == CH_COLON) begin
            // A colon always restarts framing
            next_cur.st      = ST_FRAME;
            next_cur.hi_nib  = 1'b1;
            next_cur.idx     = 9'h000;
            next_cur.sum     = 8'h00;
            next_cur.bad_hex = 1'b0;
          end else if (cur.st == ST_FRAME) begin
            if (hv[4]) begin
              next_cur.bad_hex = 1'b1;
            end
            if (cur.hi_nib) begin
              next_cur.nib    = hv[3:0];
              next_cur.hi_nib = 1'b0;
            end else begin
              next_cur.hi_nib = 1'b1;
              next_cur.idx    = cur.idx + 9'h001;
              next_cur.sum    = cur.sum + byte_in;
              case (cur.idx)
                9'd0:    next_cur.len   = byte_in;
                9'd3:    next_cur.rtype = byte_in;
                9'd4:    next_cur.d0    = byte_in;
                9'd5:    next_cur.d1    = byte_in;
                9'd6:    next_cur.d2    = byte_in;
                9'd7:    next_cur.d3    = byte_in;
                default: next_cur.nib   = cur.nib;
              endcase
              // Last byte is the checksum
              if (cur.idx != 9'd0 && cur.idx == {1'b0, cur.len} + 9'd4) begin
                next_cur.st = ST_EXEC;
              end
            end
          end
        end
      end

      ST_EXEC: begin
        next_cur.st   = ST_IDLE;
        next_cur.rpos = 2'd0;
        if (cur.sum != 8'h00 || cur.bad_hex) begin
          next_cur.reply = CH_X;
          next_cur.st    = ST_REPLY;
        end else if (cur.rtype == REC_CMD) begin
          if (cur.len == LEN_TWO && cur.d0 == OP_ERASE &&
              (cur.d1 == BLK0_SEL || cur.d1 == BLK1_SEL || cur.d1 == BLK2_SEL)) begin
            if (cur.secure) begin
              next_cur.reply = CH_P;
              next_cur.st    = ST_REPLY;
            end else begin
              next_cur.erase_req = 1'b1;
              next_cur.erase_all = 1'b0;
              next_cur.st        = ST_ERASE;
              case (cur.d1)
                BLK0_SEL: begin
                  next_cur.erase_lo = BLK0_LO;
                  next_cur.erase_hi = BLK0_HI;
                end
                BLK1_SEL: begin
                  next_cur.erase_lo = BLK1_LO;
                  next_cur.erase_hi = BLK1_HI;
                end
                default: begin
                  next_cur.erase_lo = BLK2_LO;
                  next_cur.erase_hi = BLK2_HI;
                end
              endcase
            end
          end else if (cur.len == LEN_ONE && cur.d0 == OP_FULL) begin
            // No security check here by design
            next_cur.erase_req = 1'b1;
            next_cur.erase_all = 1'b1;
            next_cur.erase_lo  = BLK0_LO;
            next_cur.erase_hi  = BLK2_HI;
            next_cur.st        = ST_ERASE;
          end else if (cur.len == LEN_TWO && cur.d0 == OP_START && cur.d1 == SUB_RESET) begin
            // Silent; a fitted reset supervisor may stretch or clip the pulse
            next_cur.wdog = 1'b1;
            next_cur.st   = ST_HALT;
          end else if (cur.len == LEN_FOUR && cur.d0 == OP_START && cur.d1 == SUB_JUMP) begin
            next_cur.jump      = 1'b1;
            next_cur.jump_addr = {cur.d2, cur.d3};
          end
        end
      end

      ST_ERASE: begin
        if (i_erase_done) begin
          next_cur.erase_req = 1'b0;
          next_cur.reply     = CH_DOT;
          next_cur.st        = ST_REPLY;
        end
      end

      ST_REPLY: begin
        // Waits until the last echo has drained
        if (!cur.tx_valid) begin
          next_cur.tx_valid = 1'b1;
          next_cur.tx_data  = reply_char(cur.reply, cur.rpos);
          next_cur.rpos     = cur.rpos + 2'd1;
          if (cur.rpos == 2'd2) begin
            next_cur.last_reply = cur.reply;
            next_cur.st         = ST_IDLE;
          end
        end
      end

      ST_HALT: begin
        // Idle loop until the watchdog resets the device
        next_cur.st = ST_HALT;
      end

      default: next_cur.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cur        <= '0;
      cur.st     <= ST_IDLE;
      cur.hi_nib <= 1'b1;
      cur.secure <= CTRL_RESET[CTRL_SECURE_BIT];
    end else begin
      cur <= next_cur;
    end
  end

  // No interrupt enable is touched by any path here
  assign o_hrdata          = cur.rd_pend ? cur.hrdata : 32'h0000_0000;
  assign o_hreadyout       = 1'b1;
  assign o_hresp           = 1'b0;
  assign o_tx_valid        = cur.tx_valid;
  assign o_tx_data         = cur.tx_data;
  assign o_erase_req       = cur.erase_req;
  assign o_erase_all       = cur.erase_all;
  assign o_erase_lo        = cur.erase_lo;
  assign o_erase_hi        = cur.erase_hi;
  assign o_watchdog_enable = cur.wdog;
  assign o_jump            = cur.jump;
  assign o_jump_addr       = cur.jump_addr;
endmodule

// ---- common/boot_cmd_pkg.sv ----
// Function
// - Successful erase replies period, CR, LF
// - Bad checksum replies X, CR, LF; no erase
// - Secured block erase replies P, CR, LF
// - Checksum first, then security, then erase
// - Type 03, length 02, data 03 00: reset start
// - Reset start enables watchdog, then idles forever
// - Length 04, data 03 01 addr: jump start
// - No reply to either start command
// - External supervisor may distort watchdog reset
// - All routines share entry point FFF0h
// - Routines never touch interrupt enables
// - Block erase: type 03, len 02, 01, 00/20/40
// - Blocks span 0000-1FFF, 2000-3FFF, 4000-7FFF
// - Full erase clears flash, restores boot defaults; the code leaves the secure bit unchanged
// - Full erase ignores security level
package boot_cmd_pkg;
  localparam logic [7:0]  CH_COLON  = 8'h3a;
  localparam logic [7:0]  CH_DOT    = 8'h2e;
  localparam logic [7:0]  CH_X      = 8'h58;
  localparam logic [7:0]  CH_P      = 8'h50;
  localparam logic [7:0]  CH_CR     = 8'h0d;
  localparam logic [7:0]  CH_LF     = 8'h0a;
  localparam logic [7:0]  REC_CMD   = 8'h03;
  localparam logic [7:0]  LEN_ONE   = 8'h01;
  localparam logic [7:0]  LEN_TWO   = 8'h02;
  localparam logic [7:0]  LEN_FOUR  = 8'h04;
  localparam logic [7:0]  OP_ERASE  = 8'h01;
  localparam logic [7:0]  OP_START  = 8'h03;
  localparam logic [7:0]  OP_FULL   = 8'h07;
  localparam logic [7:0]  SUB_RESET = 8'h00;
  localparam logic [7:0]  SUB_JUMP  = 8'h01;
  localparam logic [7:0]  BLK0_SEL  = 8'h00;
  localparam logic [7:0]  BLK1_SEL  = 8'h20;
  localparam logic [7:0]  BLK2_SEL  = 8'h40;
  localparam logic [15:0] BLK0_LO   = 16'h0000;
  localparam logic [15:0] BLK0_HI   = 16'h1fff;
  localparam logic [15:0] BLK1_LO   = 16'h2000;
  localparam logic [15:0] BLK1_HI   = 16'h3fff;
  localparam logic [15:0] BLK2_LO   = 16'h4000;
  localparam logic [15:0] BLK2_HI   = 16'h7fff;
  localparam logic [15:0] API_ENTRY = 16'hfff0;
  localparam logic [7:0]  REG_CTRL  = 8'h00;
  localparam logic [7:0]  REG_STAT  = 8'h04;
  localparam logic [7:0]  REG_ENTRY = 8'h08;
  localparam logic [7:0]  REG_JUMP  = 8'h0c;
  localparam int          CTRL_SECURE_BIT = 0;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  typedef enum logic [2:0] {
    ST_IDLE, ST_FRAME, ST_EXEC, ST_ERASE, ST_REPLY, ST_HALT
  } state_t;
endpackage

// ---- dv/boot_cmd_chk.sv ----
`timescale 1ns/1ns
module boot_cmd_chk (
  // Clock, reset and bus
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic [31:0] o_hrdata,
  // Serial stream
  input wire logic        i_rx_valid,
  input wire logic [7:0]  i_rx_data,
  input wire logic        o_rx_ready,
  input wire logic        o_tx_valid,
  input wire logic [7:0]  o_tx_data,
  input wire logic        i_tx_ready,
  // Erase and start
  input wire logic        o_erase_req,
  input wire logic        o_erase_all,
  input wire logic [15:0] o_erase_lo,
  input wire logic [15:0] o_erase_hi,
  input wire logic        i_erase_done,
  input wire logic        o_watchdog_enable,
  input wire logic        o_jump
);
  import boot_cmd_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_erase_holds: assert property (
    o_erase_req && !i_erase_done |=> o_erase_req) else $error("erase dropped early");
  a_block_range: assert property (
    o_erase_req && !o_erase_all |-> (o_erase_lo == BLK0_LO && o_erase_hi == BLK0_HI) ||
    (o_erase_lo == BLK1_LO && o_erase_hi == BLK1_HI) ||
    (o_erase_lo == BLK2_LO && o_erase_hi == BLK2_HI)) else $error("erase range wrong");
  a_entry_read: assert property (
    i_hsel && i_hready && i_htrans[1] && !i_hwrite && i_haddr == {24'h0, REG_ENTRY}
    |=> o_hrdata == {16'h0, API_ENTRY}) else $error("entry read wrong");
  a_echo_char: assert property (
    i_rx_valid && o_rx_ready |=> o_tx_valid && o_tx_data == $past(i_rx_data))
    else $error("echo missing");
  a_tx_held: assert property (
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data)) else $error("tx dropped");
  a_dot_after: assert property (
    $fell(o_erase_req) |-> ##[0:8] o_tx_valid && o_tx_data == CH_DOT)
    else $error("no success reply");
  a_jump_pulse: assert property (o_jump |=> !o_jump) else $error("jump too long");
  a_halt_quiet: assert property (
    o_watchdog_enable |-> !o_rx_ready && !o_erase_req && !o_jump) else $error("not idle");
  a_wdog_sticky: assert property (
    o_watchdog_enable |=> o_watchdog_enable) else $error("watchdog dropped");
  cover property (o_erase_req && o_erase_all);
  cover property (o_jump);
  cover property ($rose(o_watchdog_enable));
endmodule
bind boot_command_interpreter boot_cmd_chk u_chk (.*);

// ---- dv/host_station.sv ----
`timescale 1ns/1ns
module host_station (
  // Clock and pacing
  input  wire logic        i_core_clk,
  input  wire logic        i_slow,
  // Character sink
  input  wire logic        i_tx_valid,
  input  wire logic [7:0]  i_tx_data,
  output logic             o_tx_ready,
  // Erase engine
  input  wire logic        i_erase_req,
  input  wire logic        i_erase_all,
  input  wire logic [15:0] i_erase_lo,
  input  wire logic [15:0] i_erase_hi,
  output logic             o_erase_done
);
  logic [7:0]  got[$];
  logic [15:0] lo;
  logic [15:0] hi;
  logic        all;
  logic        tgl = 1'b0;
  int          n_er = 0;
  int          busy = 0;
  // Slow mode holds ready low on every other clock cycle
  assign o_tx_ready = !i_slow || tgl;
  initial o_erase_done = 1'b0;
  always @(posedge i_core_clk) begin
    tgl <= !tgl;
    o_erase_done <= 1'b0;
    if (i_tx_valid && o_tx_ready) got.push_back(i_tx_data);
    if (i_erase_req && !o_erase_done) begin
      busy <= busy + 1;
      if (busy >= (i_slow ? 9 : 1)) begin
        o_erase_done <= 1'b1;
        busy <= 0;
        n_er <= n_er + 1;
        lo <= i_erase_lo;
        hi <= i_erase_hi;
        all <= i_erase_all;
      end
    end
  end
endmodule

// ---- dv/boot_command_interpreter_test.sv ----
`timescale 1ns/1ns
module boot_command_interpreter_test;
  import boot_cmd_pkg::*;
  typedef struct packed {
    logic [7:0] len, op, sel; logic bad, sec; logic [7:0] rep; logic [15:0] lo, hi; logic all;
  } row_t;
  row_t rows [7] = '{
    '{8'h02, OP_ERASE, BLK0_SEL, 1'b0, 1'b0, CH_DOT, BLK0_LO, BLK0_HI, 1'b0},
    '{8'h02, OP_ERASE, BLK1_SEL, 1'b0, 1'b0, CH_DOT, BLK1_LO, BLK1_HI, 1'b0},
    '{8'h02, OP_ERASE, BLK2_SEL, 1'b0, 1'b0, CH_DOT, BLK2_LO, BLK2_HI, 1'b0},
    '{8'h02, OP_ERASE, BLK0_SEL, 1'b1, 1'b1, CH_X, 16'h0, 16'h0, 1'b0},
    '{8'h02, OP_ERASE, BLK1_SEL, 1'b0, 1'b1, CH_P, 16'h0, 16'h0, 1'b0},
    '{LEN_ONE, OP_FULL, 8'h00, 1'b0, 1'b1, CH_DOT, BLK0_LO, BLK2_HI, 1'b1},
    '{8'h02, OP_ERASE, 8'h60, 1'b0, 1'b0, 8'h00, 16'h0, 16'h0, 1'b0}};
  logic i_core_clk, i_rst, i_hwrite, i_rx_valid, slow, o_hreadyout, o_rx_ready, o_tx_valid;
  logic i_tx_ready, o_erase_req, o_erase_all, i_erase_done, o_watchdog_enable, o_jump, o_hresp;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
  logic [15:0] o_erase_lo, o_erase_hi, o_jump_addr, jaddr;
  logic [7:0]  i_rx_data, o_tx_data, want[$];
  logic [1:0]  i_htrans;
  int          n_fail = 0, cmp_count = 0, cyc = 0, jcnt = 0, n0;
  boot_command_interpreter u_dut (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_hsel(1'b1), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
    .o_rx_ready(o_rx_ready), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
    .i_tx_ready(i_tx_ready), .o_erase_req(o_erase_req), .o_erase_all(o_erase_all),
    .o_erase_lo(o_erase_lo), .o_erase_hi(o_erase_hi), .i_erase_done(i_erase_done),
    .o_watchdog_enable(o_watchdog_enable), .o_jump(o_jump), .o_jump_addr(o_jump_addr));
  host_station u_host (.i_core_clk(i_core_clk), .i_slow(slow), .i_tx_valid(o_tx_valid),
    .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready), .i_erase_req(o_erase_req),
    .i_erase_all(o_erase_all), .i_erase_lo(o_erase_lo), .i_erase_hi(o_erase_hi),
    .o_erase_done(i_erase_done));
  task automatic tally_and_finish;
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    i_htrans <= 2'h2; i_haddr <= {24'h0, a}; i_hwrite <= wr;
    do @(posedge i_core_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0; i_hwdata <= wd;
    do @(posedge i_core_clk); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
    cmp({31'h0, o_hresp}, 32'h0);
  endtask
  task automatic put(input logic [7:0] ch);
    i_rx_valid <= 1'b1; i_rx_data <= ch; want.push_back(ch);
    do @(posedge i_core_clk); while (o_rx_ready !== 1'b1);
    i_rx_valid <= 1'b0;
    @(posedge i_core_clk);
  endtask
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
  endfunction
  // Bytes go out high nibble first; the sum includes the checksum itself
  task automatic frame(input logic [7:0] len, op, a, b, c, input logic bad);
    logic [7:0] by[9]; logic [7:0] s;
    by = '{len, 8'h00, 8'h00, REC_CMD, op, a, b, c, 8'h00}; s = 8'h00; put(CH_COLON);
    for (int i = 0; i < 5 + len; i++) begin
      if (i == 4 + len) by[i] = 8'h00 - s + {7'h0, bad};
      s = s + by[i]; put(hx(by[i][7:4])); put(hx(by[i][3:0]));
    end
  endtask
  task automatic settle(input logic [7:0] rep);
    if (rep != 8'h00) want = {want, rep, CH_CR, CH_LF};
    for (int k = 0; k < 400 && u_host.got.size() < want.size(); k++) @(posedge i_core_clk);
    repeat (20) @(posedge i_core_clk);
    cmp(u_host.got.size(), want.size());
    foreach (want[j]) if (j < u_host.got.size()) cmp(u_host.got[j], want[j]);
    want.delete(); u_host.got.delete();
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (o_jump === 1'b1) begin jaddr <= o_jump_addr; jcnt <= jcnt + 1; end
    if (cyc == 30000) begin n_fail++; tally_and_finish(); end
  end
  initial begin
    i_rst = 1'b1; i_rx_valid = 1'b0; i_rx_data = 8'h00; i_htrans = 2'h0; slow = 1'b0;
    i_haddr = 32'h0; i_hwrite = 1'b0; i_hwdata = 32'h0;
    repeat (8) @(posedge i_core_clk);
    i_rst <= 1'b0;
    ahb(1'b0, REG_CTRL, 32'h0); cmp(rd, CTRL_RESET);
    // Stands in for an application call; caller duties stay in software
    ahb(1'b0, REG_ENTRY, 32'h0); cmp(rd, {16'h0, API_ENTRY});
    ahb(1'b0, 8'h40, 32'h0); cmp(rd, 32'h0);
    foreach (rows[i]) begin
      ahb(1'b1, REG_CTRL, {31'h0, rows[i].sec}); slow <= i[0]; n0 = u_host.n_er;
      frame(rows[i].len, rows[i].op, rows[i].sel, 8'h00, 8'h00, rows[i].bad);
      settle(rows[i].rep);
      cmp(u_host.n_er - n0, rows[i].rep == CH_DOT);
      if (rows[i].rep == CH_DOT) cmp(u_host.all, rows[i].all);
      if (rows[i].rep == CH_DOT) cmp({u_host.lo, u_host.hi}, {rows[i].lo, rows[i].hi});
    end
    ahb(1'b0, REG_STAT, 32'h0);
    cmp(rd, {24'h0, CH_DOT});
    frame(LEN_FOUR, OP_START, SUB_JUMP, 8'h12, 8'h34, 1'b0); settle(8'h00);
    cmp({jcnt[15:0], jaddr}, 32'h0001_1234);
    ahb(1'b0, REG_JUMP, 32'h0);
    cmp(rd, 32'h0000_1234);
    frame(LEN_TWO, OP_START, SUB_RESET, 8'h00, 8'h00, 1'b0); settle(8'h00);
    cmp({o_watchdog_enable, o_rx_ready, jcnt[7:0]}, 10'h201);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    cmp(o_watchdog_enable, 1'b0);
    i_rst <= 1'b0;
    // Out of the halt loop the device must take commands again
    frame(LEN_TWO, OP_ERASE, BLK1_SEL, 8'h00, 8'h00, 1'b0);
    settle(CH_DOT);
    tally_and_finish();
  end
endmodule
